// >>> gpfcs_defines.svh
// Purpose: Constants for the pin function and compare status block.
// Assumes: 16-bit register words; 100 MHz clock.
// Notes:   Field positions and codes are named here; the package holds types.
// Summary of operation
// RL1: Protect flag sets on protect; clears on read.
// RL2: Window status latched or live per setting.
// RL3: Compare flag is synchronized comparator output.
// RL4: Filter enable inserts glitch filter, else bypass.
// RL5: Output enable bit selects output mode.
// RL6: Output select maps status bit to pin.
// RL7: Channel select bit0 channel1, bit3 channel0.
// RL8: Global functions device-wide; others per channel.
// RL9: Code 0000 edges enter/leave deep sleep.
// RL10: Code 0010 falling edge triggers fault dump.
// RL11: Code 0011 edges power current outputs.
// RL12: Code 0100 edges power voltage outputs.
// RL13: Code 0101 falling edge starts protect.
// RL14: Code 0111 low level holds clear.
// RL15: Code 1000 falling edge strobes load.
// RL16: Code 1001 edges stop/start waveform.
// RL17: Code 1010 edges margin low/high.
// RL18: Code 1011 falling resets, rising releases.
// RL19: Code 1100 edges permit/block memory program.
// RL20: Code 1101 edges unlock/lock register map.
// RL21: Input enable bit selects input mode.
// RL22: Compare clear trigger clears latched outputs.
// RL23: Busy high while channel refuses commands.
// RL24: Edges from sampled pin compare, one pulse.
// RL25: Unlisted output select drives pin low.
`ifndef GPFCS_DEFINES_SVH
`define GPFCS_DEFINES_SVH
`define GPFCS_ADDR_STATUS     8'h23
`define GPFCS_ADDR_CONFIG     8'h24
`define GPFCS_CFG_RESET       16'h0000
`define GPFCS_BIT_FILTER      15
`define GPFCS_BIT_OUT_EN      13
`define GPFCS_OSEL_HI         12
`define GPFCS_OSEL_LO         9
`define GPFCS_CSEL_HI         8
`define GPFCS_CSEL_LO         5
`define GPFCS_IFUN_HI         4
`define GPFCS_IFUN_LO         1
`define GPFCS_BIT_IN_EN       0
`define GPFCS_CSEL_CH1        0
`define GPFCS_CSEL_CH0        3
`define GPFCS_ST_PROTECT      8
`define GPFCS_ST_WIN0         7
`define GPFCS_ST_WIN1         4
`define GPFCS_ST_CMP0         3
`define GPFCS_ST_CMP1         0
`define GPFCS_OSEL_MEM_BUSY   4'h1
`define GPFCS_OSEL_CH1_BUSY   4'h4
`define GPFCS_OSEL_CH0_BUSY   4'h7
`define GPFCS_OSEL_CH1_WIN    4'h8
`define GPFCS_OSEL_CH0_WIN    4'hb
`define GPFCS_FILTER_NS       40
`define GPFCS_CLK_NS          10
`define GPFCS_FILTER_CYCLES   ((`GPFCS_FILTER_NS + `GPFCS_CLK_NS - 1) / `GPFCS_CLK_NS)
`endif

// >>> gpfcs_pkg.sv
// Purpose: Types for the pin function and compare status block.
// Assumes: Codes mirror the four-bit input function field.
// Notes:   Constants live in gpfcs_defines.svh.
package gpfcs_pkg;
    typedef enum logic [3:0] {
        GPFCS_FN_SLEEP   = 4'h0,
        GPFCS_FN_FAULT   = 4'h2,
        GPFCS_FN_IOUT    = 4'h3,
        GPFCS_FN_VOUT    = 4'h4,
        GPFCS_FN_PROTECT = 4'h5,
        GPFCS_FN_CLEAR   = 4'h7,
        GPFCS_FN_LOAD    = 4'h8,
        GPFCS_FN_WAVE    = 4'h9,
        GPFCS_FN_MARGIN  = 4'ha,
        GPFCS_FN_RESET   = 4'hb,
        GPFCS_FN_NVM     = 4'hc,
        GPFCS_FN_LOCK    = 4'hd
    } gpfcs_func_type;
    typedef enum logic [1:0] {
        GPFCS_FLT_STABLE = 2'b01,
        GPFCS_FLT_CHANGE = 2'b10
    } gpfcs_flt_type;
endpackage : gpfcs_pkg

// >>> gpfcs_filter.sv
// Purpose: Glitch filter for the pin input.
// Assumes: Input already sampled in the clock domain.
// Notes:   A change must persist for the filter count before it is accepted.
`timescale 1ns/1ps
`include "gpfcs_defines.svh"
module gpfcs_filter
    import gpfcs_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_pin,
    output logic      o_pin
);
    localparam logic [3:0] CNT_MAX = 4'(`GPFCS_FILTER_CYCLES);
    gpfcs_flt_type state_q, state_d;
    logic [3:0]    cnt_q, cnt_d;
    logic          out_q, out_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        out_d   = out_q;
        unique case (state_q)
            GPFCS_FLT_STABLE: begin
                cnt_d = 4'h0;
                if (i_pin != out_q) begin
                    state_d = GPFCS_FLT_CHANGE;
                end
            end
            GPFCS_FLT_CHANGE: begin
                // A pulse shorter than the count falls back without effect.
                if (i_pin == out_q) begin
                    state_d = GPFCS_FLT_STABLE;
                end else if (cnt_q == CNT_MAX - 4'h1) begin
                    out_d   = i_pin;
                    state_d = GPFCS_FLT_STABLE;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            default: begin
                state_d = GPFCS_FLT_STABLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_q <= GPFCS_FLT_STABLE;
            cnt_q   <= 4'h0;
            out_q   <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            out_q   <= out_d;
        end
    end

    assign o_pin = out_q;
endmodule : gpfcs_filter

// >>> gpfcs_top.sv
// Purpose: Pin function configuration, pin actions and compare status word.
// Assumes: Register port is a simple word strobe interface from the host link.
// Notes:   Action outputs are one-cycle pulses unless named as levels.
`timescale 1ns/1ps
`include "gpfcs_defines.svh"
module gpfcs_top
    import gpfcs_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_wdata,
    output logic [15:0]      o_reg_rdata,
    input  wire logic        i_pin,
    output logic             o_pin,
    output logic             o_pin_oe,
    input  wire logic [1:0]  i_compare_raw,
    input  wire logic [1:0]  i_window_raw,
    input  wire logic        i_window_latch_en,
    input  wire logic [1:0]  i_compare_clear_trigger,
    input  wire logic        i_protect_active,
    input  wire logic [1:0]  i_channel_busy,
    input  wire logic        i_memory_program_busy,
    input  wire logic [1:0]  i_sync_config,
    output logic             o_deep_sleep,
    output logic             o_fault_dump,
    output logic [1:0]       o_current_powerdown,
    output logic [1:0]       o_voltage_powerdown,
    output logic             o_protect_start,
    output logic             o_clear_input,
    output logic [1:0]       o_load_update_strobe,
    output logic [1:0]       o_wave_stop,
    output logic [1:0]       o_wave_start,
    output logic [1:0]       o_margin_low,
    output logic [1:0]       o_margin_high,
    output logic             o_device_reset,
    output logic             o_nvm_program_allow,
    output logic             o_map_locked
);
    // Channel vector index 0 is channel 0, index 1 is channel 1.

    // ----------------------------------------------------------------
    // Configuration register
    // ----------------------------------------------------------------
    logic [15:0] cfg_q, cfg_d;
    logic        status_rd;
    assign status_rd = i_reg_rd && (i_reg_addr == `GPFCS_ADDR_STATUS);

    always_comb begin
        cfg_d = cfg_q;
        if (i_reg_wr && (i_reg_addr == `GPFCS_ADDR_CONFIG)) begin
            cfg_d = i_reg_wdata & 16'hbfff;
        end
    end

    logic           filter_en, out_en, in_en;
    logic [3:0]     osel, csel;
    gpfcs_func_type ifun;
    logic [1:0]     ch_sel;
    assign filter_en = cfg_q[`GPFCS_BIT_FILTER];
    assign out_en    = cfg_q[`GPFCS_BIT_OUT_EN];
    assign in_en     = cfg_q[`GPFCS_BIT_IN_EN];
    assign osel      = cfg_q[`GPFCS_OSEL_HI:`GPFCS_OSEL_LO];
    assign csel      = cfg_q[`GPFCS_CSEL_HI:`GPFCS_CSEL_LO];
    assign ifun      = gpfcs_func_type'(cfg_q[`GPFCS_IFUN_HI:`GPFCS_IFUN_LO]);
    assign ch_sel    = {csel[`GPFCS_CSEL_CH1], csel[`GPFCS_CSEL_CH0]}; // RL7

    // ----------------------------------------------------------------
    // Comparator status
    // ----------------------------------------------------------------
    logic [1:0] cmp_s1_q, cmp_s2_q, win_s1_q, win_s2_q, win_lat_q, win_lat_d;
    logic [1:0] win_out;
    logic       prot_q, prot_d;

    always_comb begin
        // Hits are held until the clear trigger; the trigger wins being explicit.
        win_lat_d = (win_lat_q | win_s2_q) & ~i_compare_clear_trigger; // RL22
        // A protect event in the reading cycle survives the clear.
        prot_d = i_protect_active ? 1'b1 : (status_rd ? 1'b0 : prot_q); // RL1
    end

    assign win_out = i_window_latch_en ? win_lat_q : win_s2_q; // RL2

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cmp_s1_q  <= 2'b00;
            cmp_s2_q  <= 2'b00;
            win_s1_q  <= 2'b00;
            win_s2_q  <= 2'b00;
            win_lat_q <= 2'b00;
            prot_q    <= 1'b0;
            cfg_q     <= `GPFCS_CFG_RESET;
        end else begin
            cmp_s1_q  <= i_compare_raw;
            cmp_s2_q  <= cmp_s1_q; // RL3
            win_s1_q  <= i_window_raw;
            win_s2_q  <= win_s1_q;
            win_lat_q <= win_lat_d;
            prot_q    <= prot_d;
            cfg_q     <= cfg_d;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [15:0] rdata_d, rdata_q;
    always_comb begin
        rdata_d = 16'h0000;
        if (i_reg_rd && i_reg_addr == `GPFCS_ADDR_CONFIG) begin
            rdata_d = cfg_q;
        end else if (status_rd) begin
            rdata_d[`GPFCS_ST_PROTECT] = prot_q;
            rdata_d[`GPFCS_ST_WIN0]    = win_out[0];
            rdata_d[`GPFCS_ST_WIN1]    = win_out[1];
            rdata_d[`GPFCS_ST_CMP0]    = cmp_s2_q[0];
            rdata_d[`GPFCS_ST_CMP1]    = cmp_s2_q[1];
        end
    end

    // ----------------------------------------------------------------
    // Pin input path
    // ----------------------------------------------------------------
    logic pin_s1_q, pin_s2_q, pin_filt, pin_cur, pin_prev_q;
    logic rise, fall;

    gpfcs_filter u_filter (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_pin    (pin_s2_q),
        .o_pin    (pin_filt)
    );

    assign pin_cur = filter_en ? pin_filt : pin_s2_q; // RL4
    assign rise    = in_en && !out_en && pin_cur && !pin_prev_q; // RL24 RL21
    assign fall    = in_en && !out_en && !pin_cur && pin_prev_q; // RL24

    // ----------------------------------------------------------------
    // Pin actions
    // ----------------------------------------------------------------
    logic       sleep_d, sleep_q, fault_d, fault_q, prot_st_d, prot_st_q;
    logic       clr_d, clr_q, rst_d, rst_q, nvm_d, nvm_q, lock_d, lock_q;
    logic [1:0] ipd_d, ipd_q, vpd_d, vpd_q, ld_d, ld_q;
    logic [1:0] wstop_d, wstop_q, wstart_d, wstart_q, mlo_d, mlo_q, mhi_d, mhi_q;

    always_comb begin
        sleep_d   = sleep_q;
        ipd_d     = ipd_q;
        vpd_d     = vpd_q;
        rst_d     = rst_q;
        nvm_d     = nvm_q;
        lock_d    = lock_q;
        fault_d   = 1'b0;
        prot_st_d = 1'b0;
        clr_d     = 1'b0;
        ld_d      = 2'b00;
        wstop_d   = 2'b00;
        wstart_d  = 2'b00;
        mlo_d     = 2'b00;
        mhi_d     = 2'b00;
        // Only listed codes act; any other code is ignored as invalid.
        case (ifun) // RL8
            GPFCS_FN_SLEEP: begin
                if (fall) sleep_d = 1'b1; // RL9
                if (rise) sleep_d = 1'b0; // RL9
            end
            GPFCS_FN_FAULT: begin
                fault_d = fall; // RL10
            end
            GPFCS_FN_IOUT: begin
                if (fall) ipd_d = ipd_q | ch_sel; // RL11
                if (rise) ipd_d = ipd_q & ~ch_sel; // RL11
            end
            GPFCS_FN_VOUT: begin
                if (fall) vpd_d = vpd_q | ch_sel; // RL12
                if (rise) vpd_d = vpd_q & ~ch_sel; // RL12
            end
            GPFCS_FN_PROTECT: begin
                prot_st_d = fall; // RL13
            end
            GPFCS_FN_CLEAR: begin
                clr_d = in_en && !out_en && !pin_cur; // RL14
            end
            GPFCS_FN_LOAD: begin
                ld_d = fall ? (ch_sel & i_sync_config) : 2'b00; // RL15
            end
            GPFCS_FN_WAVE: begin
                wstop_d  = fall ? ch_sel : 2'b00; // RL16
                wstart_d = rise ? ch_sel : 2'b00; // RL16
            end
            GPFCS_FN_MARGIN: begin
                mlo_d = fall ? ch_sel : 2'b00; // RL17
                mhi_d = rise ? ch_sel : 2'b00; // RL17
            end
            GPFCS_FN_RESET: begin
                if (fall) rst_d = 1'b1; // RL18
                if (rise) rst_d = 1'b0; // RL18
            end
            GPFCS_FN_NVM: begin
                if (fall) nvm_d = 1'b1; // RL19
                if (rise) nvm_d = 1'b0; // RL19
            end
            GPFCS_FN_LOCK: begin
                if (fall) lock_d = 1'b0; // RL20
                if (rise) lock_d = 1'b1; // RL20
            end
            default: begin
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Pin output path
    // ----------------------------------------------------------------
    logic pin_out_d, pin_out_q, pin_oe_q;
    always_comb begin
        unique case (osel) // RL6
            `GPFCS_OSEL_MEM_BUSY: pin_out_d = i_memory_program_busy;
            `GPFCS_OSEL_CH1_BUSY: pin_out_d = i_channel_busy[1]; // RL23
            `GPFCS_OSEL_CH0_BUSY: pin_out_d = i_channel_busy[0]; // RL23
            `GPFCS_OSEL_CH1_WIN:  pin_out_d = win_out[1];
            `GPFCS_OSEL_CH0_WIN:  pin_out_d = win_out[0];
            default:              pin_out_d = 1'b0; // RL25
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pin_s1_q   <= 1'b1;
            pin_s2_q   <= 1'b1;
            pin_prev_q <= 1'b1;
            sleep_q    <= 1'b0;
            fault_q    <= 1'b0;
            ipd_q      <= 2'b00;
            vpd_q      <= 2'b00;
            prot_st_q  <= 1'b0;
            clr_q      <= 1'b0;
            ld_q       <= 2'b00;
            wstop_q    <= 2'b00;
            wstart_q   <= 2'b00;
            mlo_q      <= 2'b00;
            mhi_q      <= 2'b00;
            rst_q      <= 1'b0;
            nvm_q      <= 1'b0;
            lock_q     <= 1'b0;
            pin_out_q  <= 1'b0;
            pin_oe_q   <= 1'b0;
            rdata_q    <= 16'h0000;
        end else begin
            pin_s1_q   <= i_pin;
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_cur;
            sleep_q    <= sleep_d;
            fault_q    <= fault_d;
            ipd_q      <= ipd_d;
            vpd_q      <= vpd_d;
            prot_st_q  <= prot_st_d;
            clr_q      <= clr_d;
            ld_q       <= ld_d;
            wstop_q    <= wstop_d;
            wstart_q   <= wstart_d;
            mlo_q      <= mlo_d;
            mhi_q      <= mhi_d;
            rst_q      <= rst_d;
            nvm_q      <= nvm_d;
            lock_q     <= lock_d;
            pin_out_q  <= pin_out_d & out_en;
            pin_oe_q   <= out_en; // RL5
            rdata_q    <= rdata_d;
        end
    end

    assign o_reg_rdata          = rdata_q;
    assign o_pin                = pin_out_q;
    assign o_pin_oe             = pin_oe_q;
    assign o_deep_sleep         = sleep_q;
    assign o_fault_dump         = fault_q;
    assign o_current_powerdown  = ipd_q;
    assign o_voltage_powerdown  = vpd_q;
    assign o_protect_start      = prot_st_q;
    assign o_clear_input        = clr_q;
    assign o_load_update_strobe = ld_q;
    assign o_wave_stop          = wstop_q;
    assign o_wave_start         = wstart_q;
    assign o_margin_low         = mlo_q;
    assign o_margin_high        = mhi_q;
    assign o_device_reset       = rst_q;
    assign o_nvm_program_allow  = nvm_q;
    assign o_map_locked         = lock_q;
endmodule : gpfcs_top

// >>> gpfcs_chk.sv
// Purpose: Port-level checks for gpfcs_top.
// Assumes: A shadow of the config word follows host writes.
// Notes:   Bound into every gpfcs_top instance.
`timescale 1ns/1ps
`include "gpfcs_defines.svh"
module gpfcs_chk
    import gpfcs_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic [7:0]  i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        i_pin,
    input wire logic        o_pin,
    input wire logic        o_pin_oe,
    input wire logic [1:0]  i_compare_raw,
    input wire logic        i_protect_active,
    input wire logic        o_fault_dump,
    input wire logic        o_protect_start,
    input wire logic        o_clear_input,
    input wire logic [1:0]  o_wave_start,
    input wire logic [1:0]  o_margin_high
);
    // ----------------
    // Config shadow
    // ----------------
    logic [15:0] cfg_q, cfg_d;
    logic        in_ok, quiet;
    always_comb begin
        cfg_d = cfg_q;
        if (i_reg_wr && i_reg_addr == `GPFCS_ADDR_CONFIG) begin
            cfg_d = i_reg_wdata;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cfg_q <= `GPFCS_CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end
    // Pin actions only run with input mode on and output mode off.
    assign in_ok = cfg_q[0] && !cfg_q[13];
    assign quiet = !cfg_q[13] || !(cfg_q[12:9] inside {4'h1, 4'h4, 4'h7, 4'h8, 4'hb});
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence rd_st;
        i_reg_rd && i_reg_addr == `GPFCS_ADDR_STATUS;
    endsequence
    sequence rd_idle;
        rd_st ##0 !i_protect_active;
    endsequence
    chk_protect_edge: assert property (
        in_ok && !cfg_q[15] && cfg_q[4:1] == 4'h5 && $fell(i_pin) |-> ##3 o_protect_start ##1 !o_protect_start)
        else $error("protect pulse wrong after falling pin");
    chk_fault_single: assert property (o_fault_dump |=> !o_fault_dump)
        else $error("fault pulse longer than one cycle");
    chk_oe_follow: assert property (o_pin_oe == $past(cfg_q[13]))
        else $error("pin enable does not follow config");
    chk_pin_quiet: assert property (quiet && $past(quiet) |-> !o_pin)
        else $error("pin driven high without a source");
    chk_input_off: assert property (
        (!in_ok)[*4] |-> !(o_fault_dump || o_protect_start || (|o_wave_start) || (|o_margin_high)))
        else $error("pin action while input mode off");
    chk_protect_set: assert property (
        $past(i_reg_rd && i_reg_addr == `GPFCS_ADDR_STATUS) && $past(i_protect_active)
        && $past(i_protect_active, 2) |-> o_reg_rdata[8])
        else $error("protect flag missing during protect");
    chk_protect_clr: assert property (rd_idle ##1 !i_protect_active ##1 rd_idle |=> !o_reg_rdata[8])
        else $error("protect flag not cleared by read");
    chk_cmp_sync: assert property (
        $stable(i_compare_raw)[*4] ##0 rd_st |=> o_reg_rdata[3] == $past(i_compare_raw[0])
        && o_reg_rdata[0] == $past(i_compare_raw[1]))
        else $error("compare flags wrong in status");
    chk_clear_level: assert property (
        (in_ok && !cfg_q[15] && cfg_q[4:1] == 4'h7 && !i_pin)[*4] |-> o_clear_input)
        else $error("clear not held while pin low");
endmodule : gpfcs_chk
bind gpfcs_top gpfcs_chk gpfcs_chk_inst (.*);

// >>> gpfcs_pin_model.sv
// Purpose: External circuit on the pin: drives a level and senses the pin.
// Assumes: The bench resolves the wire; the block wins while it drives.
// Notes:   Senses only while the block drives, so no stale level is reported.
`timescale 1ns/1ps
module gpfcs_pin_model (
    input  wire logic i_clk,
    input  wire logic i_level,
    input  wire logic i_pin_oe,
    input  wire logic i_wire,
    output logic      o_level,
    output logic      o_seen
);
    assign o_level = i_level;
    always_ff @(posedge i_clk) begin
        o_seen <= i_pin_oe & i_wire;
    end
endmodule : gpfcs_pin_model

// >>> test_gpfcs_top.sv
// Purpose: Self-checking bench for gpfcs_top.
// Assumes: Stimulus changes at the falling clock edge.
// Notes:   Action outputs are gathered into one vector for comparison.
`timescale 1ns/1ps
`include "gpfcs_defines.svh"
module test_gpfcs_top;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic [7:0]  i_reg_addr = 8'h00;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic [1:0]  i_compare_raw = 2'h0, i_window_raw = 2'h0, i_compare_clear_trigger = 2'h0;
    logic [1:0]  i_channel_busy = 2'h0, i_sync_config = 2'h1;
    logic        i_window_latch_en = 1'b0, i_protect_active = 1'b0, i_memory_program_busy = 1'b0;
    logic        pin_lv = 1'b1;
    wire logic   i_pin;
    logic        mdl_lv, mdl_seen, o_pin, o_pin_oe, o_deep_sleep, o_fault_dump, o_protect_start;
    logic        o_clear_input, o_device_reset, o_nvm_program_allow, o_map_locked;
    logic [1:0]  o_current_powerdown, o_voltage_powerdown, o_load_update_strobe, o_wave_stop;
    logic [1:0]  o_wave_start, o_margin_low, o_margin_high;
    logic [15:0] o_reg_rdata;
    logic [20:0] acts;
    logic [20:0] seen;
    int          error_cnt = 0;
    int          tests_run = 0;
    localparam logic [20:0] pulse_mask = 21'h085ff8;
    localparam logic [20:0] level_mask = 21'h17a007;
    assign acts = {o_deep_sleep, o_fault_dump, o_current_powerdown, o_voltage_powerdown, o_protect_start,
        o_clear_input, o_load_update_strobe, o_wave_stop, o_wave_start, o_margin_low, o_margin_high,
        o_device_reset, o_nvm_program_allow, o_map_locked};
    assign i_pin = o_pin_oe ? o_pin : mdl_lv;
    always #5 i_clk = ~i_clk;
    gpfcs_top gpfcs_top_inst (.*);
    gpfcs_pin_model gpfcs_pin_model_inst (.i_clk, .i_level(pin_lv), .i_pin_oe(o_pin_oe), .i_wire(i_pin),
        .o_level(mdl_lv), .o_seen(mdl_seen));
    // ----------------
    // Helpers
    // ----------------
    task wrap_up;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task cmp_a(input logic [20:0] got, input logic [20:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_a
    task cmp_d(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_d
    task cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        d = o_reg_rdata;
    endtask : rd
    // Pulses are gathered over the window; levels are judged at its end.
    task pin_go(input logic lv, input int n);
        @(negedge i_clk);
        pin_lv = lv;
        repeat (n) begin
            @(posedge i_clk);
            #1;
            seen = seen | (acts & pulse_mask);
        end
    endtask : pin_go
    function automatic logic [20:0] exp_act(input logic [3:0] c, input logic f, input logic [1:0] m);
        logic [20:0] e;
        e = '0;
        case (c)
            4'h0: e[20] = f;
            4'h2: e[19] = f;
            4'h3: e[18:17] = f ? m : 2'h0;
            4'h4: e[16:15] = f ? m : 2'h0;
            4'h5: e[14] = f;
            4'h7: e[13] = f;
            4'h8: e[12:11] = f ? (m & i_sync_config) : 2'h0;
            4'h9: if (f) e[10:9] = m; else e[8:7] = m;
            4'ha: if (f) e[6:5] = m; else e[4:3] = m;
            4'hb: e[2] = f;
            4'hc: e[1] = f;
            4'hd: e[0] = !f;
            default: e = '0;
        endcase
        return e;
    endfunction : exp_act
    task run_code(input logic [3:0] c, input logic [3:0] cs);
        wr(`GPFCS_ADDR_CONFIG, {7'h00, cs, c, 1'b1});
        seen = '0;
        pin_go(1'b0, 10);
        cmp_a(seen | (acts & level_mask), exp_act(c, 1'b1, {cs[0], cs[3]}));
        seen = '0;
        pin_go(1'b1, 10);
        cmp_a(seen | (acts & level_mask), exp_act(c, 1'b0, {cs[0], cs[3]}));
    endtask : run_code
    // ----------------
    // Scenarios
    // ----------------
    task t_regs;
        logic [15:0] d;
        rd(`GPFCS_ADDR_CONFIG, d);
        cmp_d(d, `GPFCS_CFG_RESET);
        wr(`GPFCS_ADDR_CONFIG, 16'hffff);
        wr(8'h30, 16'h0000);
        rd(`GPFCS_ADDR_CONFIG, d);
        cmp_d(d, 16'hbfff);
        rd(8'h30, d);
        cmp_d(d, 16'h0000);
        wr(`GPFCS_ADDR_CONFIG, 16'h0000);
    endtask : t_regs
    task t_out;
        logic [3:0] sel [5] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'hb};
        for (int k = 0; k < 5; k++) begin
            wr(`GPFCS_ADDR_CONFIG, {3'b001, sel[k], 9'h000});
            {i_memory_program_busy, i_channel_busy, i_window_raw[1:0]} = 5'h10 >> k;
            cyc(8);
            cmp_d({14'h0, mdl_seen, o_pin_oe}, 16'h0003);
            {i_memory_program_busy, i_channel_busy, i_window_raw[1:0]} = 5'h00;
            cyc(8);
            cmp_d({14'h0, mdl_seen, o_pin_oe}, 16'h0001);
        end
        wr(`GPFCS_ADDR_CONFIG, 16'h2400);
        {i_memory_program_busy, i_channel_busy, i_window_raw[1:0]} = 5'h1f;
        cyc(8);
        cmp_d({14'h0, mdl_seen, o_pin_oe}, 16'h0001);
        {i_memory_program_busy, i_channel_busy, i_window_raw[1:0]} = 5'h00;
        wr(`GPFCS_ADDR_CONFIG, 16'h0000);
        cyc(4);
    endtask : t_out
    task t_status;
        logic [15:0] d;
        i_compare_raw = 2'b01;
        i_window_raw = 2'b10;
        cyc(6);
        rd(`GPFCS_ADDR_STATUS, d);
        cmp_d(d, 16'h0018);
        i_compare_raw = 2'b00;
        i_window_raw = 2'b00;
        i_window_latch_en = 1'b1;
        i_compare_clear_trigger = 2'b11;
        cyc(2);
        i_compare_clear_trigger = 2'b00;
        i_window_raw = 2'b01;
        cyc(3);
        i_window_raw = 2'b00;
        cyc(6);
        rd(`GPFCS_ADDR_STATUS, d);
        cmp_d(d & 16'h0090, 16'h0080);
        i_compare_clear_trigger = 2'b01;
        cyc(1);
        i_compare_clear_trigger = 2'b00;
        cyc(4);
        rd(`GPFCS_ADDR_STATUS, d);
        cmp_d(d & 16'h0090, 16'h0000);
        i_window_latch_en = 1'b0;
        i_protect_active = 1'b1;
        cyc(2);
        rd(`GPFCS_ADDR_STATUS, d);
        cmp_d(d & 16'h0100, 16'h0100);
        i_protect_active = 1'b0;
        rd(`GPFCS_ADDR_STATUS, d);
        cmp_d(d & 16'h0100, 16'h0100);
        rd(`GPFCS_ADDR_STATUS, d);
        cmp_d(d & 16'h0100, 16'h0000);
    endtask : t_status
    // A two-cycle glitch must pass only with the filter bypassed.
    task t_filter;
        wr(`GPFCS_ADDR_CONFIG, 16'h800b);
        seen = '0;
        pin_go(1'b0, 2);
        pin_go(1'b1, 12);
        cmp_a(seen, 21'h000000);
        wr(`GPFCS_ADDR_CONFIG, 16'h000b);
        seen = '0;
        pin_go(1'b0, 2);
        pin_go(1'b1, 12);
        cmp_a(seen, 21'h004000);
        wr(`GPFCS_ADDR_CONFIG, 16'h800b);
        seen = '0;
        pin_go(1'b0, 14);
        cmp_a(seen, 21'h004000);
        pin_go(1'b1, 14);
    endtask : t_filter
    task t_codes;
        run_code(4'h3, 4'h1);
        run_code(4'h8, 4'h9);
        for (int c = 0; c < 14; c++) begin
            run_code(c[3:0], 4'h8);
        end
    endtask : t_codes
    initial begin
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        i_resetn = 1'b1;
        t_regs;
        t_out;
        t_status;
        t_filter;
        t_codes;
        wrap_up;
    end
    // The full run needs about 590 cycles; the limit leaves wide margin.
    initial begin
        #100000;
        error_cnt++;
        wrap_up;
    end
endmodule : test_gpfcs_top
